// ### src/bjtr_defs.vh
// Register map, field positions, reset values and timing for the block
`ifndef BJTR_DEFS_VH
`define BJTR_DEFS_VH
// ****************************************
// Register word indices (byte address is the index times four)
// ****************************************
`define BJTR_IDX_JUMPER       12'h1d2
`define BJTR_IDX_RESPONSE     12'h1d3
`define BJTR_IDX_IRQ_STATUS   12'h1d4
`define BJTR_IDX_IRQ_MASK     12'h1d5
`define BJTR_ADDR_W           14
// ****************************************
// Field positions
// ****************************************
`define BJTR_JMP_ONE_BIT      1
`define BJTR_JMP_TWO_BIT      0
`define BJTR_TO_FLAG_BIT      7
`define BJTR_TO_ACT_HI        5
`define BJTR_TO_ACT_LO        4
`define BJTR_MON_FLAG_BIT     3
`define BJTR_MON_ACT_HI       1
`define BJTR_MON_ACT_LO       0
// ****************************************
// Action encodings and reset values
// ****************************************
`define BJTR_ACT_NONE         2'h0
`define BJTR_ACT_WARM         2'h1
`define BJTR_ACT_COLD         2'h2
`define BJTR_ACT_OFF          2'h3
`define BJTR_MON_THERMAL      2'h1
`define BJTR_ACT_RESET        2'h0
`define BJTR_MASK_RESET       2'h0
// ****************************************
// Timing
// ****************************************
`define BJTR_CLK_HZ           25000000
`define BJTR_COLD_OFF_MS      4000
`define BJTR_WARM_RST_US      100
`endif

// ### src/bjtr_ctrl.v
// Jumper report and watchdog/monitor timeout response controller
`timescale 1ns/100ps
`include "bjtr_defs.vh"
// ****************************************
// Contract
// ****************************************
//
// Contract
// - Read-only jumper register at 0x1d2 whose bits 7 to 2 read zero.
// - Jumper bit 1 shows the first jumper, 1 when fitted, write-proof.
// - Jumper bit 0 shows the second jumper, 1 when fitted, write-proof.
// - An 8-bit timeout response register sits at 0x1d3.
// - Resets, power-off and interrupts fire on a flag pin going low; bits 7, 3 and the thermal alarm follow the pin level.
// - Response bit 7 reads 1 while the timeout flag pin is low.
// - Bits 5:4 pick the timeout action, 00 nothing and 01 warm reset.
// - Warm reset pulses a system reset while power stays on.
// - Cold reset drops board power about four seconds then restores.
// - A power-off action turns the board off on a timeout.
// - Response bit 3 reads 1 while the monitor alert pin is low.
// - Bits 1:0 pick the monitor action: none, thermal alarm, cold.
module bjtr_ctrl #(
  parameter integer COLD_OFF_CYCLES =
    (`BJTR_CLK_HZ / 1000) * `BJTR_COLD_OFF_MS,
  parameter integer WARM_CYCLES =
    (`BJTR_CLK_HZ / 1000000) * `BJTR_WARM_RST_US
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [13:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg         wb_ack_o,
  input  wire        jumper_input_one,
  input  wire        jumper_input_two,
  input  wire        timeout_flag_pin,
  input  wire        monitor_alert_pin,
  output reg         sys_reset_n,
  output reg         board_power_en,
  output reg         thermal_alarm_out,
  output wire        irq
);

// ****************************************
// Reset release and pin synchronisers
// ****************************************
reg  [1:0] rst_sync;
wire       rst_n = rst_sync[1];
always @(posedge clk or negedge nrst) begin
  if (!nrst) rst_sync <= 2'h0;
  else rst_sync <= {rst_sync[0], 1'b1};
end

reg  [3:0] pin_s1;
reg  [3:0] pin_s2;
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    pin_s1 <= 4'hf;
    pin_s2 <= 4'hf;
  end else begin
    pin_s1 <= {jumper_input_one, jumper_input_two,
               timeout_flag_pin, monitor_alert_pin};
    pin_s2 <= pin_s1;
  end
end
wire jmp_one   = pin_s2[3];
wire jmp_two   = pin_s2[2];
wire to_active = ~pin_s2[1];
wire mon_active = ~pin_s2[0];

reg  to_prev;
reg  mon_prev;
wire to_rise  = to_active & ~to_prev;
wire mon_rise = mon_active & ~mon_prev;

// ****************************************
// Register file
// ****************************************
reg  [1:0] timeout_action_select;
reg  [1:0] monitor_action_select;
reg  [1:0] irq_status;
reg  [1:0] irq_mask;

wire [11:0] idx  = wb_adr_i[13:2];
wire        req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire        wr0  = req & wb_we_i & wb_sel_i[0];
wire        rd   = req & ~wb_we_i;

wire [7:0] jumper_input_reg =
  {6'h00, jmp_one, jmp_two};
wire [7:0] timeout_response_reg =
  {to_active, 1'b0, timeout_action_select,
   mon_active, 1'b0, monitor_action_select};

reg [7:0] rd_mux;
always @* begin
  case (idx)
    `BJTR_IDX_JUMPER:     rd_mux = jumper_input_reg;
    `BJTR_IDX_RESPONSE:   rd_mux = timeout_response_reg;
    `BJTR_IDX_IRQ_STATUS: rd_mux = {6'h00, irq_status};
    `BJTR_IDX_IRQ_MASK:   rd_mux = {6'h00, irq_mask};
    default:              rd_mux = 8'h00;
  endcase
end

// Read of the status clears it, but a fresh event in that cycle wins
wire clr_stat = rd & (idx == `BJTR_IDX_IRQ_STATUS);
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h0;
    timeout_action_select <= `BJTR_ACT_RESET;
    monitor_action_select <= `BJTR_ACT_RESET;
    irq_mask   <= `BJTR_MASK_RESET;
    irq_status <= 2'h0;
    to_prev    <= 1'b0;
    mon_prev   <= 1'b0;
  end else begin
    wb_ack_o <= req;
    wb_dat_o <= rd ? {24'h0, rd_mux} : 32'h0;
    to_prev  <= to_active;
    mon_prev <= mon_active;
    if (wr0 && idx == `BJTR_IDX_RESPONSE) begin
      timeout_action_select <=
        wb_dat_i[`BJTR_TO_ACT_HI:`BJTR_TO_ACT_LO];
      monitor_action_select <=
        wb_dat_i[`BJTR_MON_ACT_HI:`BJTR_MON_ACT_LO];
    end
    if (wr0 && idx == `BJTR_IDX_IRQ_MASK)
      irq_mask <= wb_dat_i[1:0];
    irq_status <= (clr_stat ? 2'h0 : irq_status) | {mon_rise, to_rise};
  end
end
assign irq = |(irq_status & irq_mask);

// ****************************************
// Response sequencer
// ****************************************
localparam [1:0] ST_RUN  = 2'h0;
localparam [1:0] ST_WARM = 2'h1;
localparam [1:0] ST_COLD = 2'h2;
localparam [1:0] ST_OFF  = 2'h3;

reg  [1:0]  state;
reg  [31:0] cnt;
reg  [1:0]  next_state;
reg  [31:0] next_cnt;

// Acting on the edge only: a flag held low does not loop resets forever
wire go_warm = to_rise && timeout_action_select == `BJTR_ACT_WARM;
wire go_cold = (to_rise && timeout_action_select == `BJTR_ACT_COLD) ||
               (mon_rise && monitor_action_select == `BJTR_ACT_COLD);
wire go_off  = to_rise && timeout_action_select == `BJTR_ACT_OFF;

always @* begin
  next_state = state;
  next_cnt   = cnt;
  case (state)
    ST_RUN: begin
      if (go_off) next_state = ST_OFF;
      else if (go_cold) begin
        next_state = ST_COLD;
        next_cnt   = COLD_OFF_CYCLES;
      end else if (go_warm) begin
        next_state = ST_WARM;
        next_cnt   = WARM_CYCLES;
      end
    end
    ST_WARM, ST_COLD: begin
      if (cnt <= 32'h1) next_state = ST_RUN;
      else next_cnt = cnt - 32'h1;
    end
    ST_OFF:  next_state = ST_OFF; // Only a reset brings power back
    default: next_state = ST_RUN;
  endcase
end

always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    state <= ST_RUN;
    cnt   <= 32'h0;
    sys_reset_n <= 1'b1;
    board_power_en <= 1'b1;
    thermal_alarm_out <= 1'b0;
  end else begin
    state <= next_state;
    cnt   <= next_cnt;
    sys_reset_n <= (next_state == ST_RUN);
    board_power_en <= (next_state != ST_COLD) &&
                      (next_state != ST_OFF);
    thermal_alarm_out <= mon_active &&
      monitor_action_select == `BJTR_MON_THERMAL;
  end
end

endmodule // bjtr_ctrl

// ### bench/bjtr_assertions.sv
// Bus and output checks for the response block
`timescale 1ns/100ps
module bjtr_checker (
  input wire        clk,
  input wire        nrst,
  input wire [13:0] wb_adr_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire        sys_reset_n,
  input wire        board_power_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_ack_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data off ack");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper bits");
  a_jumper_spare: assert property (
    wb_ack_o && $past(wb_adr_i[13:2]) == 12'h1d2
    |-> wb_dat_o[7:2] == 6'h0)
    else $error("jumper spare");
  a_resp_spare: assert property (
    wb_ack_o && $past(wb_adr_i[13:2]) == 12'h1d3
    |-> !wb_dat_o[6] && !wb_dat_o[2])
    else $error("response spare");
  a_off_reset: assert property (
    !board_power_en |-> !sys_reset_n)
    else $error("power off without reset");
  c_warm: cover property ($fell(sys_reset_n) && board_power_en);
  c_power: cover property ($fell(board_power_en));
  c_read: cover property (wb_ack_o && wb_dat_o[7]);
endmodule // bjtr_checker
bind bjtr_ctrl bjtr_checker i_chk (.clk(clk), .nrst(nrst),
  .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .sys_reset_n(sys_reset_n),
  .board_power_en(board_power_en));

// ### bench/bjtr_far_side.sv
// External flag chip: pulls its flag pins low on command
`timescale 1ns/100ps
module bjtr_far_side (
  input  wire clk,
  input  wire wdt_fire,
  input  wire mon_fire,
  output reg  timeout_flag_pin = 1'b1,
  output reg  monitor_alert_pin = 1'b1
);
  // Pins idle high, so no false flag edge before the first clock
  always @(posedge clk) begin
    timeout_flag_pin <= !wdt_fire;
    monitor_alert_pin <= !mon_fire;
  end
endmodule // bjtr_far_side

// ### bench/bjtr_bench.sv
// Self-checking bench for the response block
`timescale 1ns/100ps
module board_jumper_and_timeout_response_bench;
  logic        clk, nrst, we, cyc, stb, ack, j1, j2, wf, mf, tp, mp;
  logic        srn, pwr, alarm, irq;
  logic [13:0] adr;
  logic [31:0] wd, rd;
  logic [7:0]  r;
  logic [3:0]  sel, bsel;
  int          fails, checks_done;
  wire  [3:0]  outs = {irq, alarm, pwr, srn};
  bjtr_ctrl #(.COLD_OFF_CYCLES(20), .WARM_CYCLES(5)) i_dut (.clk(clk),
    .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(wd), .wb_dat_o(rd), .wb_we_i(we),
    .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .jumper_input_one(j1), .jumper_input_two(j2), .timeout_flag_pin(tp),
    .monitor_alert_pin(mp), .sys_reset_n(srn), .board_power_en(pwr),
    .thermal_alarm_out(alarm), .irq(irq));
  bjtr_far_side i_far (.clk(clk), .wdt_fire(wf), .mon_fire(mf),
    .timeout_flag_pin(tp), .monitor_alert_pin(mp));
  task close_out;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic [11:0] idx, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk);
    adr <= {idx, 2'h0};
    we <= w;
    sel <= bsel;
    wd <= {24'h0, d};
    {cyc, stb} <= 2'h3;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rd[7:0];
    {cyc, stb} <= 2'h0;
    chk(8'(ack), 8'h1);
    if (ack !== 1'b1) close_out;
  endtask
  // Pins pass a synchroniser, so outputs lag by several cycles
  task await(input int s, input logic v);
    int n;
    n = 0;
    while (outs[s] !== v && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk(8'(outs[s]), 8'(v));
    if (outs[s] !== v) close_out;
  endtask
  task do_reset;
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task t_jumpers;
    for (int k = 0; k < 4; k++) begin
      {j1, j2} <= k[1:0];
      repeat (4) @(posedge clk);
      bus(12'h1d2, 1'b1, 8'hff);
      bus(12'h1d2, 1'b0, 8'h0);
      chk(r, {6'h0, k[1:0]});
    end
  endtask
  task t_regs;
    bus(12'h1d3, 1'b1, 8'hff);
    bus(12'h1d3, 1'b0, 8'h0);
    chk(r, 8'h33);
    // Low byte lane off: the write must be dropped
    bsel = 4'he;
    bus(12'h1d3, 1'b1, 8'h00);
    bsel = 4'hf;
    bus(12'h1d3, 1'b0, 8'h0);
    chk(r, 8'h33);
    bus(12'h1ff, 1'b0, 8'h0);
    chk(r, 8'h00);
  endtask
  task t_flags;
    bus(12'h1d3, 1'b1, 8'h00);
    bus(12'h1d5, 1'b1, 8'h03);
    wf <= 1'b1;
    mf <= 1'b1;
    await(3, 1'b1);
    bus(12'h1d3, 1'b0, 8'h0);
    chk(r, 8'h88);
    chk(8'(srn & pwr), 8'h1);
    bus(12'h1d4, 1'b0, 8'h0);
    chk(r, 8'h03);
    await(3, 1'b0);
    {wf, mf} <= 2'h0;
  endtask
  task t_timeout(input logic [1:0] a);
    bus(12'h1d3, 1'b1, {2'h0, a, 4'h0});
    wf <= 1'b1;
    await(0, 1'b0);
    if (a == 2'h1) chk(8'(pwr), 8'h1);
    else await(1, 1'b0);
    wf <= 1'b0;
    if (a == 2'h3) begin
      repeat (40) @(posedge clk);
      chk(8'(pwr), 8'h0);
      do_reset;
    end else begin
      await(1, 1'b1);
      await(0, 1'b1);
    end
  endtask
  task t_monitor;
    bus(12'h1d3, 1'b1, 8'h01);
    mf <= 1'b1;
    await(2, 1'b1);
    // Mask is clear after the reset, so the event stays silent
    chk(8'(irq), 8'h0);
    mf <= 1'b0;
    await(2, 1'b0);
    bus(12'h1d3, 1'b1, 8'h02);
    mf <= 1'b1;
    await(1, 1'b0);
    await(1, 1'b1);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {nrst, we, cyc, stb, j1, j2, wf, mf} = 8'h0;
    adr = 14'h0;
    wd = 32'h0;
    sel = 4'h0;
    bsel = 4'hf;
    do_reset;
    t_jumpers;
    t_regs;
    t_flags;
    for (int a = 1; a < 4; a++) t_timeout(a[1:0]);
    t_monitor;
    close_out;
  end
endmodule // board_jumper_and_timeout_response_bench
